// file: core/cecr_defs.svh
// constants for the converter and engine configuration slice
// assumes inclusion by bare name from every design file of the slice
`ifndef CECR_DEFS_SVH
`define CECR_DEFS_SVH

// ==========================================================================
// address decode
`define CECR_SPACE_NIB 4'h2
`define CECR_ADDR_ENG_CTRL 16'h2106
`define CECR_ADDR_ENG_BASE 16'h2109
`define CECR_ADDR_CONV_CLK 16'h2200
`define CECR_ADDR_ID_HIGH 16'h2300
`define CECR_ADDR_ID_LOW 16'h2301
`define CECR_ADDR_ANALOG 16'h2704

// ==========================================================================
// field positions
`define CECR_CE_EN_BIT 0
`define CECR_CHOP_LSB 2
`define CECR_CHOP_MSB 3
`define CECR_BASE_MSB 5
`define CECR_DIV_BIT 5
`define CECR_ADC_EN_BIT 4

// ==========================================================================
// reset and wake values
`define CECR_CE_EN_RST 1'h0
`define CECR_CE_EN_WAKE 1'h0
`define CECR_CHOP_RST 2'h0
`define CECR_CHOP_WAKE 2'h0
`define CECR_BASE_RST 6'h1f
`define CECR_BASE_WAKE 6'h1f
`define CECR_DIV_RST 1'h0
`define CECR_DIV_WAKE 1'h0
`define CECR_ADC_EN_RST 1'h0
`define CECR_ADC_EN_WAKE 1'h0
`define CECR_BYTE_ZERO 8'h00

// ==========================================================================
// chop encodings and polarity
`define CECR_CHOP_TOGGLE_A 2'h0
`define CECR_CHOP_POSITIVE 2'h1
`define CECR_CHOP_REVERSED 2'h2
`define CECR_CHOP_TOGGLE_B 2'h3
`define CECR_POL_POSITIVE 1'h0
`define CECR_POL_REVERSED 1'h1

// ==========================================================================
// clock rates and ratios
`define CECR_MCK_SLOW_HZ 25'h0600000
`define CECR_MCK_FAST_HZ 25'h12c0000
`define CECR_DIV4_SHIFT 2
`define CECR_DIV8_SHIFT 3
`define CECR_DIV4_HALF 2'h1
`define CECR_DIV8_HALF 2'h3
`define CECR_BASE_SHIFT_ZERO 10'h000
`define CECR_RATE_RST 25'h0000000
`define CECR_ADDR_RST 16'h0000

`endif

// file: core/cecr_pkg.sv
// types shared by the configuration slice and its two helpers
// assumes the defs header is on the include path
`include "cecr_defs.svh"
package cecr_pkg;

    // ======================================================================
    // engine sequencing states, one-hot
    typedef enum logic [2:0] {
        CECR_ENG_IDLE = 3'h1,
        CECR_ENG_START = 3'h2,
        CECR_ENG_RUN = 3'h4
    } cecr_eng_state_t;

    // ======================================================================
    // register slice state
    typedef struct packed {
        logic ce_en;
        logic [1:0] chop_mode;
        logic [5:0] base;
        logic div_sel;
        logic adc_en;
        logic bias_low;
        logic [7:0] rdata;
        cecr_eng_state_t eng_state;
        logic eng_start;
        logic eng_run;
        logic [15:0] eng_addr;
        logic [24:0] mck_hz;
        logic [24:0] conv_hz;
    } cecr_regs_st_t;

    // ======================================================================
    // chop sequencer state
    typedef struct packed {
        logic sync_prev;
        logic pol;
    } cecr_chop_st_t;

    // ======================================================================
    // clock divider state
    typedef struct packed {
        logic [1:0] cnt;
        logic div_clk;
    } cecr_div_st_t;

endpackage

// file: core/cecr_clkdiv.sv
// converter and decimation filter clock divider from the master clock
// assumes div_sel comes from logic on mclk
`include "cecr_defs.svh"
module cecr_clkdiv (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // control
    input wire logic div_sel,
    // divided clock
    output logic div_clk
);
    import cecr_pkg::*;

    cecr_div_st_t st_q;
    cecr_div_st_t st_d;

    // ======================================================================
    // half-period counter; >= compare recovers when the ratio shrinks
    always_comb
    begin
        logic [1:0] half;
        half = div_sel ? `CECR_DIV8_HALF : `CECR_DIV4_HALF;
        st_d = st_q;
        if (st_q.cnt >= half)
        begin
            st_d.cnt = 2'h0;
            st_d.div_clk = ~st_q.div_clk;
        end
        else
        begin
            st_d.cnt = st_q.cnt + 2'h1;
        end
    end

    // state register
    always_ff @(posedge mclk)
    begin
        if (srst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign div_clk = st_q.div_clk;

    // ======================================================================
    // checks
    property p_div4_period;
        @(posedge mclk) disable iff (srst)
        ($changed(div_clk) && !div_sel) ##1 !div_sel |-> !$changed(div_clk) ##1 $changed(div_clk);
    endproperty
    a_div4_period: assert property (p_div4_period) else $error("div4 half period wrong");

endmodule

// file: core/cecr_chop.sv
// reference chop polarity sequencer, stepped by the mux frame sync
// assumes frame sync and accumulation end come from logic on mclk
`include "cecr_defs.svh"
module cecr_chop (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // control
    input wire logic [1:0] chop_mode,
    // frame timing
    input wire logic mux_frame_sync,
    input wire logic accum_end,
    // polarity
    output logic chop_polarity
);
    import cecr_pkg::*;

    cecr_chop_st_t st_q;
    cecr_chop_st_t st_d;
    logic sync_rise;

    assign sync_rise = mux_frame_sync && !st_q.sync_prev;

    // ======================================================================
    // polarity moves only on a frame sync rising edge
    always_comb
    begin
        st_d = st_q;
        st_d.sync_prev = mux_frame_sync;
        if (sync_rise)
        begin
            case (chop_mode)
                `CECR_CHOP_POSITIVE: st_d.pol = `CECR_POL_POSITIVE;
                `CECR_CHOP_REVERSED: st_d.pol = `CECR_POL_REVERSED;
                default:
                begin
                    // accumulation end edge keeps polarity so intervals pair up
                    if (!accum_end)
                        st_d.pol = ~st_q.pol;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge mclk)
    begin
        if (srst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign chop_polarity = st_q.pol;

    // ======================================================================
    // checks
    property p_no_edge_hold;
        @(posedge mclk) disable iff (srst)
        !sync_rise |=> $stable(chop_polarity);
    endproperty
    a_no_edge_hold: assert property (p_no_edge_hold) else $error("polarity moved off edge");

    property p_fixed_modes;
        @(posedge mclk) disable iff (srst)
        sync_rise && (chop_mode == `CECR_CHOP_POSITIVE || chop_mode == `CECR_CHOP_REVERSED)
        |=> chop_polarity == $past(chop_mode[1]);
    endproperty
    a_fixed_modes: assert property (p_fixed_modes) else $error("fixed chop mode wrong");

    property p_toggle;
        @(posedge mclk) disable iff (srst)
        sync_rise && (chop_mode[0] == chop_mode[1]) && !accum_end
        |=> chop_polarity != $past(chop_polarity);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle missed");

    property p_skip_end;
        @(posedge mclk) disable iff (srst)
        sync_rise && (chop_mode[0] == chop_mode[1]) && accum_end |=> $stable(chop_polarity);
    endproperty
    a_skip_end: assert property (p_skip_end) else $error("end edge toggled");

endmodule

// file: core/cecr_regs.sv
// converter and compute engine configuration registers on the data bus
// assumes byte accesses from the host processor on mclk; one cycle strobes
// Operation
// - converter clock is master clock over four, or eight when divider bit set.
// - master clock rate is 6.291456 MHz, or 19.660800 MHz in high-rate mode.
// - engine fetch starts at 1024 times base field; base resets and wakes to 31.
// - chop polarity changes only on rising mux frame sync edges.
// - chop codes 00/11 toggle, 01 holds positive, 10 holds reversed.
// - toggle modes skip the change at the accumulation end edge.
// - converter enable turns on converter and reference; cleared lowers bias; resets 0.
// - 16-bit read-only identity over two bytes, high byte at lower address.
// - write-only configuration bits read back as zero.
// - writable bits take defined values on reset and on wake.
// - read-only and battery-backed bits are untouched by reset and wake.
// - frequent bits sit in special function space, the rest in 0x2xxx data space.
`include "cecr_defs.svh"
module cecr_regs #(
    parameter logic [15:0] PART_IDENTITY = 16'h5a3c // arbitrary value
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // wake from battery mode, one cycle pulse
    input wire logic wake,
    // host processor data bus
    input wire logic sfr_sel,
    input wire logic [15:0] regs_addr,
    input wire logic regs_wr,
    input wire logic regs_rd,
    input wire logic [7:0] regs_wdata,
    output logic [7:0] regs_rdata,
    // clock system
    input wire logic pll_fast,
    output logic [24:0] mclk_rate_hz,
    output logic [24:0] conv_rate_hz,
    output logic conv_clk,
    // chop timing
    input wire logic mux_frame_sync,
    input wire logic accum_end,
    output logic chop_polarity,
    // compute engine
    output logic engine_start,
    output logic engine_run,
    output logic [15:0] engine_base_addr,
    // analog control
    output logic adc_enable,
    output logic vref_enable,
    output logic bias_reduce
);
    import cecr_pkg::*;

    cecr_regs_st_t st_q;
    cecr_regs_st_t st_d;
    logic in_space;
    logic wr_hit;
    logic rd_hit;

    // ======================================================================
    // decode; special function space holds none of these bits
    assign in_space = !sfr_sel && (regs_addr[15:12] == `CECR_SPACE_NIB);
    assign wr_hit = regs_wr && in_space;
    assign rd_hit = regs_rd && in_space;

    // ======================================================================
    // next state
    always_comb
    begin
        logic [7:0] rbyte;
        rbyte = `CECR_BYTE_ZERO;
        st_d = st_q;

        // register writes, loaded by the host processor
        if (wr_hit)
        begin
            case (regs_addr)
                `CECR_ADDR_ENG_CTRL:
                begin
                    st_d.ce_en = regs_wdata[`CECR_CE_EN_BIT];
                    st_d.chop_mode = regs_wdata[`CECR_CHOP_MSB:`CECR_CHOP_LSB];
                end
                `CECR_ADDR_ENG_BASE: st_d.base = regs_wdata[`CECR_BASE_MSB:0];
                `CECR_ADDR_CONV_CLK: st_d.div_sel = regs_wdata[`CECR_DIV_BIT];
                `CECR_ADDR_ANALOG: st_d.adc_en = regs_wdata[`CECR_ADC_EN_BIT];
                default: ;
            endcase
        end

        // wake re-initialises writable bits and beats a same-cycle write
        if (wake)
        begin
            st_d.ce_en = `CECR_CE_EN_WAKE;
            st_d.chop_mode = `CECR_CHOP_WAKE;
            st_d.base = `CECR_BASE_WAKE;
            st_d.div_sel = `CECR_DIV_WAKE;
            st_d.adc_en = `CECR_ADC_EN_WAKE;
        end

        // read data; unstored bits and unmapped bytes give zero
        case (regs_addr)
            `CECR_ADDR_ENG_CTRL:
            begin
                rbyte[`CECR_CE_EN_BIT] = st_q.ce_en;
                rbyte[`CECR_CHOP_MSB:`CECR_CHOP_LSB] = st_q.chop_mode;
            end
            `CECR_ADDR_ENG_BASE: rbyte[`CECR_BASE_MSB:0] = st_q.base;
            `CECR_ADDR_CONV_CLK: rbyte[`CECR_DIV_BIT] = st_q.div_sel;
            `CECR_ADDR_ID_HIGH: rbyte = PART_IDENTITY[15:8];
            `CECR_ADDR_ID_LOW: rbyte = PART_IDENTITY[7:0];
            `CECR_ADDR_ANALOG: rbyte[`CECR_ADC_EN_BIT] = st_q.adc_en;
            default: rbyte = `CECR_BYTE_ZERO;
        endcase
        if (regs_rd)
            st_d.rdata = rd_hit ? rbyte : `CECR_BYTE_ZERO;

        // analog enables; bias drops whenever the converter is off
        st_d.bias_low = !st_q.adc_en;

        // clock rates follow the pll mode and divider select
        st_d.mck_hz = pll_fast ? `CECR_MCK_FAST_HZ : `CECR_MCK_SLOW_HZ;
        st_d.conv_hz = st_d.mck_hz >> (st_q.div_sel ? `CECR_DIV8_SHIFT : `CECR_DIV4_SHIFT);

        // engine base address in bytes
        st_d.eng_addr = {st_q.base, `CECR_BASE_SHIFT_ZERO};

        // engine sequencing; a start pulse marks fetch from the base
        st_d.eng_start = 1'b0;
        case (st_q.eng_state)
            CECR_ENG_IDLE:
            begin
                if (st_q.ce_en)
                begin
                    st_d.eng_state = CECR_ENG_START;
                    st_d.eng_start = 1'b1;
                end
            end
            CECR_ENG_START: st_d.eng_state = st_q.ce_en ? CECR_ENG_RUN : CECR_ENG_IDLE;
            CECR_ENG_RUN:
            begin
                if (!st_q.ce_en)
                    st_d.eng_state = CECR_ENG_IDLE;
            end
            default: st_d.eng_state = CECR_ENG_IDLE;
        endcase
        st_d.eng_run = (st_d.eng_state != CECR_ENG_IDLE);
    end

    // ======================================================================
    // state register; identity is a constant and never loaded
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            st_q <= '0;
            st_q.ce_en <= `CECR_CE_EN_RST;
            st_q.chop_mode <= `CECR_CHOP_RST;
            st_q.base <= `CECR_BASE_RST;
            st_q.div_sel <= `CECR_DIV_RST;
            st_q.adc_en <= `CECR_ADC_EN_RST;
            st_q.bias_low <= 1'b1;
            st_q.eng_state <= CECR_ENG_IDLE;
            st_q.mck_hz <= `CECR_RATE_RST;
            st_q.conv_hz <= `CECR_RATE_RST;
            st_q.eng_addr <= `CECR_ADDR_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ======================================================================
    // helpers
    cecr_clkdiv u_clkdiv (
        .mclk(mclk),
        .srst(srst),
        .div_sel(st_q.div_sel),
        .div_clk(conv_clk)
    );

    cecr_chop u_chop (
        .mclk(mclk),
        .srst(srst),
        .chop_mode(st_q.chop_mode),
        .mux_frame_sync(mux_frame_sync),
        .accum_end(accum_end),
        .chop_polarity(chop_polarity)
    );

    // outputs straight from the state register
    assign regs_rdata = st_q.rdata;
    assign mclk_rate_hz = st_q.mck_hz;
    assign conv_rate_hz = st_q.conv_hz;
    assign engine_start = st_q.eng_start;
    assign engine_run = st_q.eng_run;
    assign engine_base_addr = st_q.eng_addr;
    assign adc_enable = st_q.adc_en;
    assign vref_enable = st_q.adc_en;
    assign bias_reduce = st_q.bias_low;

    // ======================================================================
    // checks
    property p_conv_rate;
        @(posedge mclk) disable iff (srst)
        1'b1 |=> conv_rate_hz == (($past(pll_fast) ? `CECR_MCK_FAST_HZ : `CECR_MCK_SLOW_HZ)
            >> ($past(st_q.div_sel) ? `CECR_DIV8_SHIFT : `CECR_DIV4_SHIFT));
    endproperty
    a_conv_rate: assert property (p_conv_rate) else $error("converter rate wrong");

    property p_mck_rate;
        @(posedge mclk) disable iff (srst)
        pll_fast |=> mclk_rate_hz == `CECR_MCK_FAST_HZ;
    endproperty
    a_mck_rate: assert property (p_mck_rate) else $error("fast master rate wrong");

    property p_wake_base;
        @(posedge mclk) disable iff (srst)
        wake |=> ##1 engine_base_addr == {`CECR_BASE_WAKE, `CECR_BASE_SHIFT_ZERO};
    endproperty
    a_wake_base: assert property (p_wake_base) else $error("wake base not 31");

    property p_wake_analog;
        @(posedge mclk) disable iff (srst)
        wake |=> !adc_enable && !vref_enable ##1 bias_reduce;
    endproperty
    a_wake_analog: assert property (p_wake_analog) else $error("analog not off on wake");

    property p_id_high;
        @(posedge mclk) disable iff (srst)
        regs_rd && !sfr_sel && regs_addr == `CECR_ADDR_ID_HIGH |=> regs_rdata == PART_IDENTITY[15:8];
    endproperty
    a_id_high: assert property (p_id_high) else $error("identity high byte wrong");

    property p_ctrl_zero_bits;
        @(posedge mclk) disable iff (srst)
        regs_rd && !sfr_sel && regs_addr == `CECR_ADDR_ENG_CTRL
        |=> regs_rdata[7:4] == 4'h0 && regs_rdata[1] == 1'b0;
    endproperty
    a_ctrl_zero_bits: assert property (p_ctrl_zero_bits) else $error("unstored bits not zero");

    property p_out_of_space;
        @(posedge mclk) disable iff (srst)
        regs_rd && (sfr_sel || regs_addr[15:12] != `CECR_SPACE_NIB) |=> regs_rdata == `CECR_BYTE_ZERO;
    endproperty
    a_out_of_space: assert property (p_out_of_space) else $error("foreign space answered");

    property p_engine_idle;
        @(posedge mclk) disable iff (srst)
        !st_q.ce_en |=> !engine_run && !engine_start;
    endproperty
    a_engine_idle: assert property (p_engine_idle) else $error("engine ran while disabled");

    property p_engine_start;
        @(posedge mclk) disable iff (srst)
        st_q.eng_state == CECR_ENG_IDLE && st_q.ce_en
        |=> engine_start && engine_run && engine_base_addr == {$past(st_q.base), `CECR_BASE_SHIFT_ZERO};
    endproperty
    a_engine_start: assert property (p_engine_start) else $error("engine start wrong");

    // slow pll setting must give the low master rate
    property p_mck_slow;
        @(posedge mclk) disable iff (srst)
        !pll_fast |=> mclk_rate_hz == `CECR_MCK_SLOW_HZ;
    endproperty
    a_mck_slow: assert property (p_mck_slow) else $error("slow master rate wrong");

    // bias trails the converter enable by one edge
    property p_bias_follow;
        @(posedge mclk) disable iff (srst)
        1'b1 |=> bias_reduce == !$past(adc_enable);
    endproperty
    a_bias_follow: assert property (p_bias_follow) else $error("bias not following enable");

    // reference always shares the converter enable
    property p_vref_follow;
        @(posedge mclk) disable iff (srst)
        1'b1 |-> vref_enable == adc_enable;
    endproperty
    a_vref_follow: assert property (p_vref_follow) else $error("reference enable split");

    // low identity byte at the higher address
    property p_id_low;
        @(posedge mclk) disable iff (srst)
        regs_rd && !sfr_sel && regs_addr == `CECR_ADDR_ID_LOW |=> regs_rdata == PART_IDENTITY[7:0];
    endproperty
    a_id_low: assert property (p_id_low) else $error("identity low byte wrong");

    // read byte stands until the next read strobe
    property p_rdata_hold;
        @(posedge mclk) disable iff (srst)
        !regs_rd |=> $stable(regs_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read byte moved without strobe");

endmodule

// file: test/test_cecr_regs.sv
// self-checking bench for the converter and engine configuration slice
// assumes the core/ files are compiled first; the bench drives every port
`include "cecr_defs.svh"
module test_cecr_regs;
    timeunit 1ns;
    timeprecision 1ns;

    // ======================================================================
    // signals and bench state
    localparam logic [15:0] ID = 16'h6b1d; // arbitrary value
    localparam logic [15:0] RA [4] = '{16'h2106, 16'h2109, 16'h2200, 16'h2704};
    localparam logic [7:0] RM [4] = '{8'h0d, 8'h3f, 8'h20, 8'h10};
    localparam logic [7:0] RV [4] = '{8'h00, 8'h1f, 8'h00, 8'h00};
    logic mclk = 1'b0, srst = 1'b1, wake = 1'b0, sfr_sel = 1'b0;
    logic regs_wr = 1'b0, regs_rd = 1'b0, pll_fast = 1'b0;
    logic mux_frame_sync = 1'b0, accum_end = 1'b0;
    logic [15:0] regs_addr = 16'h0000;
    logic [7:0] regs_wdata = 8'h00;
    logic [7:0] regs_rdata;
    logic [24:0] mclk_rate_hz, conv_rate_hz;
    logic [15:0] engine_base_addr;
    logic conv_clk, chop_polarity, engine_start, engine_run;
    logic adc_enable, vref_enable, bias_reduce;
    int err_count = 0;
    int n_compared = 0;
    logic [15:0] lfsr_q = 16'h218a;
    logic [7:0] exp_q [$];
    logic rd_seen = 1'b0;
    logic pol_exp = 1'b0;

    cecr_regs #(.PART_IDENTITY(ID)) dut (
        .mclk(mclk), .srst(srst), .wake(wake), .sfr_sel(sfr_sel),
        .regs_addr(regs_addr), .regs_wr(regs_wr), .regs_rd(regs_rd),
        .regs_wdata(regs_wdata), .regs_rdata(regs_rdata), .pll_fast(pll_fast),
        .mclk_rate_hz(mclk_rate_hz), .conv_rate_hz(conv_rate_hz), .conv_clk(conv_clk),
        .mux_frame_sync(mux_frame_sync), .accum_end(accum_end),
        .chop_polarity(chop_polarity), .engine_start(engine_start),
        .engine_run(engine_run), .engine_base_addr(engine_base_addr),
        .adc_enable(adc_enable), .vref_enable(vref_enable), .bias_reduce(bias_reduce)
    );

    // 100 ns master clock
    always #50 mclk = ~mclk;

    // ======================================================================
    // helpers
    function automatic logic [7:0] rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q[7:0];
    endfunction

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chkw(input logic [24:0] got, input logic [24:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe; sfr selects the special function space
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic special_function_register);
        @(posedge mclk);
        regs_addr <= a;
        regs_wdata <= d;
        sfr_sel <= special_function_register;
        regs_wr <= 1'b1;
        @(posedge mclk);
        regs_wr <= 1'b0;
        sfr_sel <= 1'b0;
    endtask

    // read strobe; the expected byte waits in the queue for the monitor
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge mclk);
        regs_addr <= a;
        regs_rd <= 1'b1;
        exp_q.push_back(exp);
        @(posedge mclk);
        regs_rd <= 1'b0;
    endtask

    // sample levels at a falling edge so the clock edge updates have landed
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask

    // frame sync held high three cycles: only the rising edge may count
    task automatic frame(input logic [1:0] m, input logic acc);
        @(posedge mclk);
        mux_frame_sync <= 1'b1;
        accum_end <= acc;
        @(posedge mclk);
        accum_end <= 1'b0;
        repeat (2) @(posedge mclk);
        mux_frame_sync <= 1'b0;
        settle(1);
        if (m == 2'h1)
            pol_exp = 1'b0;
        else if (m == 2'h2)
            pol_exp = 1'b1;
        else if (!acc)
            pol_exp = ~pol_exp;
        chk8({7'h00, chop_polarity}, {7'h00, pol_exp});
    endtask

    task automatic defaults();
        for (int i = 0; i < 4; i++)
            rd(RA[i], RV[i]);
        rd(`CECR_ADDR_ID_HIGH, ID[15:8]);
        rd(`CECR_ADDR_ID_LOW, ID[7:0]);
        settle(2);
        chkw({9'h000, engine_base_addr}, 25'h0007c00);
        chk8({3'h0, engine_run, engine_start, adc_enable, vref_enable, bias_reduce}, 8'h01);
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ======================================================================
    // read monitor: the byte stands one edge after the strobe is taken
    always @(posedge mclk)
    begin
        if (rd_seen)
            chk8(regs_rdata, exp_q.pop_front());
        rd_seen = regs_rd;
    end

    // watchdog, far beyond the few hundred cycles the sequence needs
    initial
    begin
        repeat (20000) @(posedge mclk);
        err_count++;
        finish_test();
    end

    // ======================================================================
    // main sequence
    initial
    begin
        logic [7:0] d;
        int n;
        logic prev;
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        defaults();
        // random data through every stored byte, unstored bits read zero
        for (int i = 0; i < 4; i++)
            for (int j = 0; j < 3; j++)
            begin
                d = rnd();
                wr(RA[i], d, 1'b0);
                rd(RA[i], d & RM[i]);
            end
        // refused writes: identity, special function space, outside 0x2xxx
        wr(`CECR_ADDR_ID_HIGH, ~ID[15:8], 1'b0);
        rd(`CECR_ADDR_ID_HIGH, ID[15:8]);
        wr(`CECR_ADDR_ENG_BASE, 8'h05, 1'b0);
        wr(`CECR_ADDR_ENG_BASE, 8'h2a, 1'b1);
        wr(16'h3109, 8'h11, 1'b0);
        rd(`CECR_ADDR_ENG_BASE, 8'h05);
        rd(16'h3109, 8'h00);
        rd(16'h2107, 8'h00);
        settle(2);
        chkw({9'h000, engine_base_addr}, 25'h0001400);
        wr(`CECR_ADDR_ENG_BASE, 8'hff, 1'b0);
        settle(2);
        chkw({9'h000, engine_base_addr}, 25'h000fc00);
        d = rnd();
        wr(`CECR_ADDR_ENG_BASE, d, 1'b0);
        settle(2);
        chkw({9'h000, engine_base_addr}, {9'h000, d[5:0], 10'h000});
        // engine idles while disabled, then one start pulse from the base
        wr(`CECR_ADDR_ENG_CTRL, 8'h00, 1'b0);
        wr(`CECR_ADDR_ENG_BASE, 8'h03, 1'b0);
        settle(2);
        chk8({7'h00, engine_run}, 8'h00);
        wr(`CECR_ADDR_ENG_CTRL, 8'h01, 1'b0);
        n = 0;
        repeat (6)
        begin
            @(negedge mclk);
            if (engine_start === 1'b1)
            begin
                n++;
                chkw({9'h000, engine_base_addr}, 25'h0000c00);
            end
        end
        chkw(n, 25'h0000001);
        chk8({7'h00, engine_run}, 8'h01);
        wr(`CECR_ADDR_ENG_CTRL, 8'h00, 1'b0);
        settle(2);
        chk8({7'h00, engine_run}, 8'h00);
        // converter enable drives converter, reference and bias
        wr(`CECR_ADDR_ANALOG, 8'h10, 1'b0);
        settle(2);
        chk8({5'h00, adc_enable, vref_enable, bias_reduce}, 8'h06);
        wr(`CECR_ADDR_ANALOG, 8'hef, 1'b0);
        settle(2);
        chk8({5'h00, adc_enable, vref_enable, bias_reduce}, 8'h01);
        // rates and divided clock for both pll settings and both ratios
        for (int p = 0; p < 2; p++)
            for (int v = 0; v < 2; v++)
            begin
                @(posedge mclk);
                pll_fast <= p[0];
                wr(`CECR_ADDR_CONV_CLK, {2'h0, v[0], 5'h00}, 1'b0);
                settle(16);
                n = 0;
                prev = conv_clk;
                repeat (64)
                begin
                    @(negedge mclk);
                    if (conv_clk !== prev)
                        n++;
                    prev = conv_clk;
                end
                chkw(n, v ? 25'h0000010 : 25'h0000020);
                chkw(mclk_rate_hz, p ? 25'h12c0000 : 25'h0600000);
                chkw(conv_rate_hz, (p ? 25'h12c0000 : 25'h0600000) >> (v ? 3 : 2));
            end
        // chop modes: no change without a frame edge, accumulation end skips
        for (int m = 0; m < 4; m++)
        begin
            wr(`CECR_ADDR_ENG_CTRL, {4'h0, m[1:0], 2'h0}, 1'b0);
            settle(3);
            chk8({7'h00, chop_polarity}, {7'h00, pol_exp});
            frame(m[1:0], 1'b0);
            frame(m[1:0], 1'b0);
            frame(m[1:0], 1'b1);
        end
        // wake restores the defaults, identity untouched
        wr(`CECR_ADDR_ENG_BASE, 8'h12, 1'b0);
        wr(`CECR_ADDR_ANALOG, 8'h10, 1'b0);
        wr(`CECR_ADDR_CONV_CLK, 8'h20, 1'b0);
        wr(`CECR_ADDR_ENG_CTRL, 8'h0c, 1'b0);
        @(posedge mclk);
        wake <= 1'b1;
        @(posedge mclk);
        wake <= 1'b0;
        settle(1);
        defaults();
        settle(2);
        finish_test();
    end
endmodule
